// ==== hw/osc_pkg.sv ====
// Shared constants and types for the oscillator switch and wake-up timer block
package osc_pkg;

  // Clock rate and timing figures
  localparam int CLK_PERIOD_NS       = 4;
  localparam int RESUME_SHORT_NS     = 128000;
  localparam int RESUME_LONG_NS      = 4000000;
  localparam int RESUME_SHORT_CYCLES = (RESUME_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_LONG_CYCLES  = (RESUME_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Base wake period, plain default value
  localparam int WAKE_BASE_NS        = 1000000;
  localparam int WAKE_BASE_CYCLES    = (WAKE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is index times four
  localparam logic [5:0] REG_CLK_CFG    = 6'h00;
  localparam logic [5:0] REG_PORT_TWO   = 6'h02;
  localparam logic [5:0] REG_INT_STATUS = 6'h04;
  localparam logic [5:0] REG_INT_MASK   = 6'h05;
  localparam logic [5:0] REG_CLK_STATUS = 6'h06;
  localparam logic [5:0] REG_POWER_CTRL = 6'h07;

  // Clock configuration fields
  localparam int         CFG_EXT_EN      = 0;
  localparam int         CFG_OUT_DIS     = 1;
  localparam int         CFG_ADJ_LO      = 4;
  localparam int         CFG_RESUME_LONG = 7;
  localparam logic [7:0] CFG_WMASK       = 8'hF3;
  localparam logic [7:0] CFG_RESET       = 8'h00;

  // Port two pin state fields
  localparam int P2_REG_BIT   = 0;
  localparam int P2_CLKIN_BIT = 1;
  localparam int P2_DMINUS    = 4;
  localparam int P2_DPLUS     = 5;

  // Interrupt status and mask fields
  localparam int         IRQ_WAKE   = 0;
  localparam int         IRQ_SWITCH = 1;
  localparam logic [1:0] IRQ_RESET  = 2'h0;

  // Power control fields
  localparam int CTRL_SUSPEND = 0;

  // Clock source sequencer states
  typedef enum logic [4:0] {
    ST_INT    = 5'h01,
    ST_HALT   = 5'h02,
    ST_RESUME = 5'h04,
    ST_EXT    = 5'h08,
    ST_SUSP   = 5'h10
  } clk_state_e;

endpackage

// ==== hw/osc_switch_wake_timer.sv ====
// Clock source sequencer, wake-up timer control and pin state port behind APB
// Operation
// - Power-up runs internal 6 MHz oscillator, buffered onto clock output pin.
// - Output-disable control stops internal clock reaching clock output pin.
// - Disabled output holds pin high; no effect in external mode.
// - Writing enable bit 0 halts clocks, stops internal, starts external oscillator.
// - Chip clocks resume from external clock only once it is stable.
// - Processor held further 128 us or 4 ms after stable, per delay bit.
// - Clearing bit 0 in external mode never returns to internal clock.
// - Wake from suspend picks source from current enable bit value.
// - External wake starts oscillator, waits stable, then applies resume delay.
// - Internal mode: clock input is pulled-down GPIO read at port two bit one.
// - Clock input pin as GPIO never raises a processor interrupt.
// - Wake timer runs only while its interrupt enable is set.
// - Wake timer ignores suspend and global enable; only its enable matters.
// - Enabled wake timer interrupts at every period end until disabled.
// - Disabling wake timer clears count, so next enable gives full period.
// - Adjust bits 6:4 scale base period by two to the field; reset zero.
// - Port two read returns live D+ and D- in bits 5:4; reserved zero.
// - Port two bit zero returns regulator pin level.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module osc_switch_wake_timer #(
  parameter int unsigned RESUME_SHORT_CYCLES = osc_pkg::RESUME_SHORT_CYCLES,
  parameter int unsigned RESUME_LONG_CYCLES  = osc_pkg::RESUME_LONG_CYCLES,
  parameter int unsigned WAKE_BASE_CYCLES    = osc_pkg::WAKE_BASE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ext_clk_stable,
  input  wire logic        wake_event,
  input  wire logic        clk_in_pin,
  input  wire logic        regulator_pin,
  input  wire logic        d_plus_pin,
  input  wire logic        d_minus_pin,
  output logic             int_osc_en,
  output logic             ext_osc_en,
  output logic             clk_sel_ext,
  output logic             chip_clk_en,
  output logic             cpu_hold,
  output logic             clk_out_drive,
  output logic             clk_out_high,
  output logic             clk_in_pulldown,
  output logic             irq
);

  typedef struct packed {
    osc_pkg::clk_state_e st;
    logic [7:0]          cfg;
    logic [1:0]          int_status;
    logic [1:0]          int_mask;
    logic [19:0]         resume_cnt;
    logic                resume_long;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                irq;
    logic                int_osc_en;
    logic                ext_osc_en;
    logic                clk_sel_ext;
    logic                chip_clk_en;
    logic                cpu_hold;
    logic                clk_out_drive;
    logic                clk_out_high;
    logic                clk_in_pulldown;
  } state_s;

  state_s     s;
  state_s     next_s;
  logic       acc_setup;
  logic       acc_commit;
  logic       wr_commit;
  logic       susp_req;
  logic       switch_done;
  logic       p2_gpio;
  logic       wake_any;
  logic [1:0] w1c;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wake_if wk ();

  wake_timer #(
    .BASE_CYCLES (WAKE_BASE_CYCLES)
  ) u_wake_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .wk      (wk)
  );

  // Timer enable is the wake interrupt mask bit alone, nothing global
  assign wk.enable = s.int_mask[osc_pkg::IRQ_WAKE];
  assign wk.adjust = s.cfg[osc_pkg::CFG_ADJ_LO +: 3];

  // Word-aligned register hit; shared by read mux and write decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = reg_hit(addr, osc_pkg::REG_CLK_CFG) || reg_hit(addr, osc_pkg::REG_PORT_TWO) ||
                 reg_hit(addr, osc_pkg::REG_INT_STATUS) || reg_hit(addr, osc_pkg::REG_INT_MASK) ||
                 reg_hit(addr, osc_pkg::REG_CLK_STATUS) || reg_hit(addr, osc_pkg::REG_POWER_CTRL);
  endfunction

  // Bus phases: answer one cycle into access, commit when pready is seen
  assign acc_setup  = psel && penable && !s.pready;
  assign acc_commit = psel && penable && s.pready;
  assign wr_commit  = acc_commit && pwrite;
  assign susp_req   = wr_commit && reg_hit(paddr, osc_pkg::REG_POWER_CTRL) && pwdata[osc_pkg::CTRL_SUSPEND];
  assign w1c        = (wr_commit && reg_hit(paddr, osc_pkg::REG_INT_STATUS)) ? pwdata[1:0] : 2'h0;
  // Clock input is a plain GPIO in internal mode; it feeds no event
  assign p2_gpio    = clk_in_pin && !s.ext_osc_en;
  assign wake_any   = wake_event || wk.tick;

  // Register, sequencer and output next-state logic
  always_comb begin
    next_s = s;
    switch_done = 1'b0;
    next_s.pready  = acc_setup;
    next_s.pslverr = acc_setup && !reg_mapped(paddr);
    // Read data sampled at the answer cycle
    if (acc_setup) begin
      next_s.prdata = 32'h0;
      if (reg_hit(paddr, osc_pkg::REG_CLK_CFG)) begin
        next_s.prdata[7:0] = s.cfg;
      end else if (reg_hit(paddr, osc_pkg::REG_PORT_TWO)) begin
        next_s.prdata[osc_pkg::P2_DPLUS]     = d_plus_pin;
        next_s.prdata[osc_pkg::P2_DMINUS]    = d_minus_pin;
        next_s.prdata[osc_pkg::P2_CLKIN_BIT] = p2_gpio;
        next_s.prdata[osc_pkg::P2_REG_BIT]   = regulator_pin;
      end else if (reg_hit(paddr, osc_pkg::REG_INT_STATUS)) begin
        next_s.prdata[1:0] = s.int_status;
      end else if (reg_hit(paddr, osc_pkg::REG_INT_MASK)) begin
        next_s.prdata[1:0] = s.int_mask;
      end else if (reg_hit(paddr, osc_pkg::REG_CLK_STATUS)) begin
        next_s.prdata[7:0] = {s.cpu_hold, s.chip_clk_en, s.clk_sel_ext, s.st};
      end
    end
    // Writes take effect only at the commit edge
    if (wr_commit && reg_hit(paddr, osc_pkg::REG_CLK_CFG)) begin
      next_s.cfg = pwdata[7:0] & osc_pkg::CFG_WMASK;
    end
    if (wr_commit && reg_hit(paddr, osc_pkg::REG_INT_MASK)) begin
      next_s.int_mask = pwdata[1:0];
    end

    // Source sequencer
    unique case (s.st)
      osc_pkg::ST_INT: begin
        if (wr_commit && reg_hit(paddr, osc_pkg::REG_CLK_CFG) && pwdata[osc_pkg::CFG_EXT_EN]) begin
          next_s.st          = osc_pkg::ST_HALT;
          next_s.resume_long = pwdata[osc_pkg::CFG_RESUME_LONG];
        end else if (susp_req) begin
          next_s.st = osc_pkg::ST_SUSP;
        end
      end
      osc_pkg::ST_HALT: begin
        // Stay gated until the external clock is stable
        if (ext_clk_stable) begin
          next_s.st = osc_pkg::ST_RESUME;
          next_s.resume_cnt = s.resume_long ? 20'(RESUME_LONG_CYCLES - 1)
                                            : 20'(RESUME_SHORT_CYCLES - 1);
        end
      end
      osc_pkg::ST_RESUME: begin
        // Delay runs on the new clock, so a lost stable flag pauses it
        if (s.resume_cnt == 20'h0) begin
          next_s.st   = osc_pkg::ST_EXT;
          switch_done = 1'b1;
        end else if (ext_clk_stable) begin
          next_s.resume_cnt = s.resume_cnt - 20'h1;
        end
      end
      osc_pkg::ST_EXT: begin
        // Clearing the enable bit is deliberately ignored here
        if (susp_req) begin
          next_s.st = osc_pkg::ST_SUSP;
        end
      end
      osc_pkg::ST_SUSP: begin
        if (wake_any) begin
          if (s.cfg[osc_pkg::CFG_EXT_EN]) begin
            next_s.st          = osc_pkg::ST_HALT;
            next_s.resume_long = s.cfg[osc_pkg::CFG_RESUME_LONG];
          end else begin
            next_s.st = osc_pkg::ST_INT;
          end
        end
      end
      default: begin
        next_s.st = osc_pkg::ST_INT;
      end
    endcase

    // Sticky events; a new event beats a same-cycle clear
    next_s.int_status = (s.int_status & ~w1c) |
                        {switch_done, wk.tick};
    next_s.irq = |(next_s.int_status & next_s.int_mask);

    // Pin and clock controls registered from the next state
    next_s.int_osc_en  = (next_s.st == osc_pkg::ST_INT);
    next_s.ext_osc_en  = (next_s.st == osc_pkg::ST_HALT) || (next_s.st == osc_pkg::ST_RESUME) ||
                         (next_s.st == osc_pkg::ST_EXT);
    next_s.clk_sel_ext = (next_s.st == osc_pkg::ST_RESUME) || (next_s.st == osc_pkg::ST_EXT);
    // Gating across halt and suspend keeps runt pulses off the chip logic
    next_s.chip_clk_en = (next_s.st == osc_pkg::ST_INT) || next_s.clk_sel_ext;
    next_s.cpu_hold    = !((next_s.st == osc_pkg::ST_INT) || (next_s.st == osc_pkg::ST_EXT));
    next_s.clk_out_drive = (next_s.st == osc_pkg::ST_INT) && !next_s.cfg[osc_pkg::CFG_OUT_DIS];
    next_s.clk_out_high  = (next_s.st == osc_pkg::ST_INT) && next_s.cfg[osc_pkg::CFG_OUT_DIS];
    // Pull-down only while the oscillator is off; it would load a starting resonator
    next_s.clk_in_pulldown = !next_s.ext_osc_en;
  end

  // State register; reset lands in internal mode with clock output on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                 <= '0;
      s.st              <= osc_pkg::ST_INT;
      s.cfg             <= osc_pkg::CFG_RESET;
      s.int_status      <= osc_pkg::IRQ_RESET;
      s.int_mask        <= osc_pkg::IRQ_RESET;
      s.int_osc_en      <= 1'b1;
      s.chip_clk_en     <= 1'b1;
      s.clk_out_drive   <= 1'b1;
      s.clk_in_pulldown <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pready          = s.pready;
  assign prdata          = s.prdata;
  assign pslverr         = s.pslverr;
  assign int_osc_en      = s.int_osc_en;
  assign ext_osc_en      = s.ext_osc_en;
  assign clk_sel_ext     = s.clk_sel_ext;
  assign chip_clk_en     = s.chip_clk_en;
  assign cpu_hold        = s.cpu_hold;
  assign clk_out_drive   = s.clk_out_drive;
  assign clk_out_high    = s.clk_out_high;
  assign clk_in_pulldown = s.clk_in_pulldown;
  assign irq             = s.irq;

  // Cycles spent in the resume delay, for checking only
  logic [19:0] hold_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 20'h0;
    end else begin
      hold_cnt <= (s.st == osc_pkg::ST_RESUME) ? hold_cnt + 20'h1 : 20'h0;
    end
  end

  sequence ext_write_seq;
    wr_commit && reg_hit(paddr, osc_pkg::REG_CLK_CFG) && pwdata[osc_pkg::CFG_EXT_EN];
  endsequence

  sequence halted_seq;
    (s.st == osc_pkg::ST_HALT) && !chip_clk_en && cpu_hold && ext_osc_en && !int_osc_en;
  endsequence

  chk_ext_switch_halts: assert property (
    (s.st == osc_pkg::ST_INT) and ext_write_seq |=> halted_seq)
    else $error("external enable did not halt clocks");

  chk_clocks_wait_stable: assert property (
    $rose(clk_sel_ext) |-> $past(ext_clk_stable) && $past(s.st == osc_pkg::ST_HALT))
    else $error("external clock selected before stable");

  chk_resume_length: assert property (
    (s.st == osc_pkg::ST_RESUME) ##1 (s.st == osc_pkg::ST_EXT) |->
      $past(hold_cnt) >= (s.resume_long ? 20'(RESUME_LONG_CYCLES - 1) : 20'(RESUME_SHORT_CYCLES - 1)))
    else $error("processor released before resume delay");

  chk_no_return: assert property (
    (s.st == osc_pkg::ST_EXT) && !susp_req |=> (s.st == osc_pkg::ST_EXT) && !int_osc_en)
    else $error("left external mode without suspend");

  chk_wake_source: assert property (
    (s.st == osc_pkg::ST_SUSP) && wake_any |=>
      (s.st == ($past(s.cfg[osc_pkg::CFG_EXT_EN]) ? osc_pkg::ST_HALT : osc_pkg::ST_INT)))
    else $error("wrong clock source after wake");

  chk_out_disable: assert property (
    (s.st == osc_pkg::ST_INT) && s.cfg[osc_pkg::CFG_OUT_DIS] |-> clk_out_high && !clk_out_drive)
    else $error("disabled clock output not held high");

  chk_port_two_read: assert property (
    acc_setup && !pwrite && reg_hit(paddr, osc_pkg::REG_PORT_TWO) |=>
      pready && (prdata[31:6] == 26'h0) && (prdata[3:2] == 2'h0) &&
      (prdata[5:4] == $past({d_plus_pin, d_minus_pin})) && (prdata[0] == $past(regulator_pin)))
    else $error("port two read data wrong");

  chk_gpio_level: assert property (
    acc_setup && !pwrite && reg_hit(paddr, osc_pkg::REG_PORT_TWO) |=>
      prdata[1] == ($past(clk_in_pin) && !$past(ext_osc_en)))
    else $error("clock input GPIO level wrong");

  chk_wake_sticky: assert property (
    wk.tick |=> s.int_status[osc_pkg::IRQ_WAKE] ##1 (irq || !s.int_mask[osc_pkg::IRQ_WAKE] || !$past(wk.enable)))
    else $error("wake tick lost or interrupt missing");

  sequence ext_wake_seq;
    (s.st == osc_pkg::ST_SUSP) && wake_any && s.cfg[osc_pkg::CFG_EXT_EN];
  endsequence

  // Pad and gate levels per state; outputs are registered with the state
  chk_int_clk_out: assert property (
    (s.st == osc_pkg::ST_INT) |-> int_osc_en && (clk_out_drive == !s.cfg[osc_pkg::CFG_OUT_DIS]))
    else $error("internal clock output state wrong");

  chk_gated_idle: assert property (
    ((s.st == osc_pkg::ST_HALT) || (s.st == osc_pkg::ST_SUSP)) |-> !chip_clk_en && cpu_hold)
    else $error("chip clock open while halted or suspended");

  chk_halt_until_stable: assert property (
    (s.st == osc_pkg::ST_HALT) && !ext_clk_stable |=> (s.st == osc_pkg::ST_HALT) && !chip_clk_en)
    else $error("halt left before external clock stable");

  // External wake restarts the oscillator with the processor still held
  chk_ext_wake_start: assert property (
    ext_wake_seq |=> ext_osc_en && !int_osc_en && cpu_hold && !chip_clk_en)
    else $error("external wake did not restart oscillator");

  chk_pulldown_mode: assert property (
    clk_in_pulldown == ((s.st == osc_pkg::ST_INT) || (s.st == osc_pkg::ST_SUSP)))
    else $error("clock input pull-down in wrong state");

  // Status bits have one source each, so pin activity cannot interrupt
  chk_wake_status_src: assert property (
    $rose(s.int_status[osc_pkg::IRQ_WAKE]) |-> $past(wk.tick))
    else $error("wake status set without a tick");

  chk_switch_status_src: assert property (
    $rose(s.int_status[osc_pkg::IRQ_SWITCH]) |-> $past(s.st == osc_pkg::ST_RESUME))
    else $error("switch status set outside resume");

endmodule

// ==== hw/wake_if.sv ====
// Control and event signals between the clock sequencer and the wake-up timer
`timescale 1ns/1ps
interface wake_if;
  logic       enable;
  logic [2:0] adjust;
  logic       tick;

  modport ctrl  (output enable, output adjust, input tick);
  modport timer (input enable, input adjust, output tick);
endinterface

// ==== hw/wake_timer.sv ====
// Periodic wake-up timer with power-of-two period adjust
`timescale 1ns/1ps
module wake_timer #(
  parameter int unsigned BASE_CYCLES = osc_pkg::WAKE_BASE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  wake_if.timer    wk
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } state_s;

  state_s      s;
  state_s      next_s;
  logic [31:0] period;

  // Period grows by powers of two; 128 times base fits 32 bits
  assign period  = 32'(BASE_CYCLES) << wk.adjust;
  assign wk.tick = s.tick;

  // Count only while enabled; disabling clears the count for a full first period
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!wk.enable) begin
      next_s.cnt = 32'h0;
    end else if (s.cnt >= period - 32'h1) begin
      next_s.cnt  = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  chk_timer_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    !wk.enable |=> (s.cnt == 32'h0) && !wk.tick)
    else $error("wake timer ran while disabled");

  chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    wk.tick && $past(wk.enable) && $stable(wk.adjust) |-> $past(s.cnt) == period - 32'h1)
    else $error("wake tick not at end of period");

endmodule

// ==== tb/osc_partner.sv ====
// External resonator model: reports stable a chosen count after being enabled
`timescale 1ns/1ps
module osc_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ext_osc_en,
  input  wire logic [15:0] start_cycles,
  output logic             ext_clk_stable
);
  logic [15:0] run_cnt;

  // Start-up count; a stopped oscillator loses stability at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt        <= 16'h0000;
      ext_clk_stable <= 1'b0;
    end else if (!ext_osc_en) begin
      run_cnt        <= 16'h0000;
      ext_clk_stable <= 1'b0;
    end else begin
      if (run_cnt < start_cycles) begin
        run_cnt <= run_cnt + 16'h0001;
      end
      ext_clk_stable <= (run_cnt >= start_cycles); // Detector level
    end
  end
endmodule

// ==== tb/osc_switch_wake_timer_tb_top.sv ====
// Self-checking bench for the oscillator switch and wake-up timer block
`timescale 1ns/1ps
module osc_switch_wake_timer_tb_top;
  localparam int SHORT_N = 20;
  localparam int LONG_N  = 50;
  localparam int BASE_N  = 10;
  localparam int LIMIT   = 20000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ext_clk_stable, wake_event, clk_in_pin, regulator_pin, d_plus_pin, d_minus_pin;
  logic        int_osc_en, ext_osc_en, clk_sel_ext, chip_clk_en, cpu_hold;
  logic        clk_out_drive, clk_out_high, clk_in_pulldown, irq;
  logic [15:0] start_cycles;
  int          error_cnt, compares, cyc, n, p, t1;
  int          adj_tab[3] = '{0, 1, 3};

  osc_switch_wake_timer #(.RESUME_SHORT_CYCLES(SHORT_N), .RESUME_LONG_CYCLES(LONG_N),
                          .WAKE_BASE_CYCLES(BASE_N)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_clk_stable(ext_clk_stable), .wake_event(wake_event), .clk_in_pin(clk_in_pin),
    .regulator_pin(regulator_pin), .d_plus_pin(d_plus_pin), .d_minus_pin(d_minus_pin),
    .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en), .clk_sel_ext(clk_sel_ext),
    .chip_clk_en(chip_clk_en), .cpu_hold(cpu_hold), .clk_out_drive(clk_out_drive),
    .clk_out_high(clk_out_high), .clk_in_pulldown(clk_in_pulldown), .irq(irq));

  osc_partner osc (.pclk(pclk), .presetn(presetn), .ext_osc_en(ext_osc_en),
                   .start_cycles(start_cycles), .ext_clk_stable(ext_clk_stable));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Cycle count, also cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k < 50), 32'h1, "no pready");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes settle two cycles so registered outputs can be looked at
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return irq;
      1: return chip_clk_en;
      2: return cpu_hold;
      default: return ext_clk_stable;
    endcase
  endfunction

  task automatic wait_lvl(input int s, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (sig(s) !== lvl && cnt < lim) begin
      @(posedge pclk);
      cnt++;
    end
    chk(32'(cnt < lim), 32'h1, "wait expired");
  endtask

  task automatic wake_pulse();
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask

  initial begin
    {error_cnt, compares, cyc} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wake_event, clk_in_pin, regulator_pin, d_plus_pin, d_minus_pin} = '0;
    start_cycles = 16'h001E;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'({int_osc_en, ext_osc_en, clk_sel_ext, chip_clk_en, cpu_hold, clk_out_drive, clk_out_high,
             clk_in_pulldown, irq}), 32'h0000012A, "reset outputs");
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0, "cfg reset");
    wr(8'h00, 32'h02);
    chk(32'({clk_out_drive, clk_out_high}), 32'h1, "out disable");
    wr(8'h00, 32'h00);
    // Pin state port over four level mixes, D+ tied to clock input
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      regulator_pin <= i[0];
      clk_in_pin    <= i[1];
      d_plus_pin    <= i[1];
      d_minus_pin   <= ~i[0];
      apb(1'b0, 8'h08, 32'h0);
      chk(q, {26'h0, i[1], ~i[0], 2'b00, i[1], i[0]}, "port two");
    end
    chk(32'(clk_in_pulldown), 32'h1, "pulldown");
    apb(1'b0, 8'h24, 32'h0);
    chk({q[30:0], e}, 32'h1, "unmapped");
    // Wake timer: a short run, a disable, then a full first period
    foreach (adj_tab[k]) begin
      p = BASE_N << adj_tab[k];
      wr(8'h00, 32'(adj_tab[k]) << 4);
      wr(8'h14, 32'h1);
      wr(8'h14, 32'h0);
      wr(8'h14, 32'h1);
      wait_lvl(0, 1'b1, 2 * p, n);
      chk(32'(n >= p - 4 && n <= p), 32'h1, "first tick");
      t1 = cyc;
      wr(8'h10, 32'h1);
      wait_lvl(0, 1'b1, 2 * p, n);
      chk(32'(cyc - t1), 32'(p), "period");
      wr(8'h14, 32'h0);
      wr(8'h10, 32'h1);
      repeat (p + 2) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0, "timer stopped");
    end
    // Raise, mask, clear
    wr(8'h14, 32'h1);
    wait_lvl(0, 1'b1, 200, n);
    wr(8'h14, 32'h0);
    chk(32'(irq), 32'h0, "masked irq");
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1, "sticky");
    wr(8'h10, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0, "cleared");
    // Clock input activity gives no interrupt
    wr(8'h14, 32'h2);
    repeat (6) @(posedge pclk) clk_in_pin <= ~clk_in_pin;
    apb(1'b0, 8'h10, 32'h0);
    chk({q[30:0], irq}, 32'h0, "gpio irq");
    // Timer tick wakes from suspend into internal mode
    wr(8'h00, 32'h20);
    wr(8'h14, 32'h1);
    wr(8'h1C, 32'h1);
    chk(32'({chip_clk_en, cpu_hold}), 32'h1, "suspended");
    wait_lvl(1, 1'b1, 60, n);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'({int_osc_en, ext_osc_en, q[0]}), 32'h5, "tick wake");
    wr(8'h14, 32'h2);
    wr(8'h10, 32'h3);
    // Switch to external, long resume delay
    clk_in_pin <= 1'b1;
    wr(8'h00, 32'h81);
    chk(32'({int_osc_en, ext_osc_en, chip_clk_en, cpu_hold, clk_in_pulldown}), 32'hA, "halt");
    wait_lvl(3, 1'b1, 100, n);
    chk(32'(chip_clk_en), 32'h0, "gated till stable");
    wait_lvl(1, 1'b1, 10, n);
    wait_lvl(2, 1'b0, LONG_N + 10, n);
    chk(32'(n >= LONG_N && n <= LONG_N + 1), 32'h1, "long resume");
    repeat (2) @(posedge pclk);
    chk(32'({clk_sel_ext, irq, clk_out_drive, clk_out_high, clk_in_pulldown}), 32'h18, "ext mode");
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(q[1]), 32'h0, "p2 bit1 ext");
    wr(8'h00, 32'h02);
    wr(8'h00, 32'h00);
    chk(32'({clk_sel_ext, int_osc_en, clk_out_high}), 32'h4, "stays ext");
    wr(8'h10, 32'h2);
    // Suspend and wake with external selected, short delay
    start_cycles <= 16'h0003;
    wr(8'h00, 32'h01);
    wr(8'h1C, 32'h1);
    chk(32'(chip_clk_en), 32'h0, "ext suspend");
    wake_pulse();
    wait_lvl(1, 1'b1, 30, n);
    wait_lvl(2, 1'b0, SHORT_N + 10, n);
    chk(32'(n >= SHORT_N && n <= SHORT_N + 1), 32'h1, "short resume");
    chk(32'({ext_osc_en, clk_sel_ext, int_osc_en}), 32'h6, "ext wake");
    // Wake with enable cleared returns to internal
    wr(8'h00, 32'h00);
    wr(8'h1C, 32'h1);
    wake_pulse();
    wait_lvl(1, 1'b1, 20, n);
    repeat (2) @(posedge pclk);
    chk(32'({int_osc_en, ext_osc_en, clk_sel_ext, clk_in_pulldown, clk_out_drive}), 32'h13, "int wake");
    wrap_up();
  end
endmodule
